// ===== logic/pulse_gen_ext_mode_config_one.sv
// Extension mode configuration one: counter feed, in-position gating, output control,
// forced ramping and phase distribution, with an AHB-Lite register slave.
// Assumes the pulse engine supplies gen_s events synchronous to clk_sys_i.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module pulse_gen_ext_mode_config_one
#(
	parameter int POS_W = 24
)
(
	input  wire logic                 clk_sys_i,
	input  wire logic                 nrst_i,
	input  wire logic                 hsel_i,
	input  wire logic [7:0]           haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic                 hready_i,
	input  wire logic [31:0]          hwdata_i,
	output logic [31:0]               hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	input  wire pulse_gen_pkg::gen_s  gen_i,
	input  wire pulse_gen_pkg::ind_s  ind_i,
	input  wire logic                 in_position_input_i,
	input  wire logic                 end_limit_input_i,
	input  wire logic                 ext_a_i,
	input  wire logic                 ext_b_i,
	output logic                      step_pulse_output_o,
	output logic                      direction_output_o,
	output logic                      end_limit_valid_o,
	output logic                      hold_o,
	output logic                      interrupt_o,
	output logic                      forced_ramp_busy_o,
	output logic [4:0]                shared_pin_o
);
	import pulse_gen_pkg::*;

	if (POS_W < 8 || POS_W > 32)
		$error("POS_W must lie between 8 and 32");

	logic [23:0]      cfg_reg;
	logic [POS_W-1:0] pos_reg;
	logic [POS_W-1:0] pos_next;
	logic [13:0]      up_rate_reg;
	logic [13:0]      dn_rate_reg;
	logic [12:0]      freq_reg;
	logic [12:0]      freq_next;
	logic [13:0]      tick_reg;
	logic [13:0]      tick_next;
	ramp_e            ramp_reg;
	ramp_e            ramp_next;
	logic             busy_reg;
	logic             wait_reg;
	logic             st_rd_reg;
	logic             st_stop_reg;
	logic             wr_pend_reg;
	logic [7:0]       wr_addr_reg;
	logic             step_out_reg;
	logic             dir_out_reg;
	logic             el_reg;
	logic             int_reg;

	// Bus decode
	logic        addr_phase;
	logic        wr_now;
	logic        wr_cfg;
	logic        wr_pos;
	logic        wr_rate;
	logic        wr_stat;
	logic [31:0] rd_mux;
	logic [4:0]  pattern;

	assign addr_phase = hsel_i & hready_i & htrans_i[1];
	assign wr_now  = wr_pend_reg;
	assign wr_cfg  = wr_now & (wr_addr_reg == ADDR_CFG);
	assign wr_pos  = wr_now & (wr_addr_reg == ADDR_POS);
	assign wr_rate = wr_now & (wr_addr_reg == ADDR_RATE);
	assign wr_stat = wr_now & (wr_addr_reg == ADDR_STAT);

	// Configuration field views
	logic [3:0] cfg_pre;
	src_e       cfg_src;
	logic       inp_pol;
	logic       inp_en;
	logic       inhibit;
	logic       out_pol;
	logic       in_pol;
	logic       rd_int_en;
	logic       force_up;
	logic       force_dn;
	logic       half_step;
	logic       five_ph;
	logic       phase_sel;

	assign cfg_pre   = cfg_reg[CFG_PRE_LSB +: 4];
	assign inp_pol   = cfg_reg[CFG_INP_POL];
	assign inp_en    = cfg_reg[CFG_INP_EN];
	assign inhibit   = cfg_reg[CFG_INHIBIT];
	assign out_pol   = cfg_reg[CFG_OUT_POL];
	assign in_pol    = cfg_reg[CFG_IN_POL];
	assign rd_int_en = cfg_reg[CFG_RDINT];
	assign force_up  = cfg_reg[CFG_FUP];
	assign force_dn  = cfg_reg[CFG_FDN];
	assign half_step = cfg_reg[CFG_HALF];
	assign five_ph   = cfg_reg[CFG_FIVE];
	assign phase_sel = cfg_reg[CFG_PHSEL];

	// Source select, first match from bit 7 down
	assign cfg_src = !cfg_reg[7] ? SRC_OUT :
		!cfg_reg[6] ? SRC_CWCCW :
		!cfg_reg[5] ? SRC_AB1 :
		!cfg_reg[4] ? SRC_AB2 : SRC_AB4;

	// Position counter feed
	logic pos_step;
	logic pos_up;

	position_feed u_feed
	(
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i),
		.src_i       (cfg_src),
		.in_pol_i    (in_pol),
		.prescale_i  (cfg_pre),
		.halt_i      (gen_i.count_halt),
		.gen_pulse_i (gen_i.pulse),
		.gen_cw_i    (gen_i.dir_cw),
		.ext_a_i     (ext_a_i),
		.ext_b_i     (ext_b_i),
		.step_o      (pos_step),
		.up_o        (pos_up)
	);

	// Software write wins over a count in the same cycle
	assign pos_next = wr_pos ? hwdata_i[POS_W-1:0] :
		pos_step ? (pos_up ? pos_reg + 1'b1 : pos_reg - 1'b1) : pos_reg;

	// Phase distributor follows the generated pulses, routed or not
	phase_distributor u_phase
	(
		.clk_sys_i  (clk_sys_i),
		.nrst_i     (nrst_i),
		.load_i     (wr_cfg),
		.load_val_i (hwdata_i[CFG_PAT_LSB +: 5]),
		.advance_i  (gen_i.pulse),
		.cw_i       (gen_i.dir_cw),
		.half_i     (hwdata_i[CFG_HALF] & wr_cfg | half_step & ~wr_cfg),
		.five_i     (hwdata_i[CFG_FIVE] & wr_cfg | five_ph & ~wr_cfg),
		.pattern_o  (pattern)
	);

	// In-position qualification
	logic inp_active;
	logic stop_fire;
	logic rd_fire;

	assign inp_active = !inp_en | (inp_pol ? in_position_input_i : ~in_position_input_i);
	assign stop_fire  = wait_reg & inp_active;
	assign rd_fire    = gen_i.ramp_down_start & gen_i.high_speed_prog & rd_int_en;

	// Forced ramping
	logic [13:0] rate_sel;
	logic        tick_wrap;

	assign rate_sel  = (ramp_reg == RAMP_DOWN) ? dn_rate_reg : up_rate_reg;
	assign tick_wrap = (rate_sel <= 14'h0001) || (tick_reg >= rate_sel - 14'h0001);

	always_comb
	begin
		ramp_next = RAMP_HOLD;
		case (ramp_reg)
			RAMP_HOLD, RAMP_UP, RAMP_DOWN:
			begin
				if (force_up && freq_reg != STEP_MAX)
					ramp_next = RAMP_UP;
				else if (force_dn && freq_reg != STEP_MIN)
					ramp_next = RAMP_DOWN;
				else
					ramp_next = RAMP_HOLD;
			end
			default:
				ramp_next = RAMP_HOLD;
		endcase
	end

	always_comb
	begin
		freq_next = freq_reg;
		tick_next = 14'h0000;
		if (ramp_reg != RAMP_HOLD && ramp_next == ramp_reg)
		begin
			tick_next = tick_wrap ? 14'h0000 : tick_reg + 14'h0001;
			if (tick_wrap)
				freq_next = (ramp_reg == RAMP_UP) ? freq_reg + 13'h0001 : freq_reg - 13'h0001;
		end
	end

	// Read mux, reserved bits read as zero
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (haddr_i)
			ADDR_CFG:
				rd_mux = {8'h00, cfg_reg[23:21], pattern, cfg_reg[15:0]};
			ADDR_POS:
				rd_mux[POS_W-1:0] = pos_reg;
			ADDR_RATE:
				rd_mux = {2'b00, dn_rate_reg, 2'b00, up_rate_reg};
			ADDR_FREQ:
				rd_mux = {19'h00000, freq_reg};
			ADDR_STAT:
				rd_mux = {28'h0000000, ~busy_reg, wait_reg, st_stop_reg, st_rd_reg};
			default:
				rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_o    <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite_i & (hsize_i == 3'h2);
			wr_addr_reg <= haddr_i;
			if (addr_phase && !hwrite_i)
				hrdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			cfg_reg     <= CFG_RST;
			pos_reg     <= POS_RST[POS_W-1:0];
			up_rate_reg <= RATE_RST;
			dn_rate_reg <= RATE_RST;
		end
		else
		begin
			if (wr_cfg)
				cfg_reg <= hwdata_i[23:0];
			pos_reg <= pos_next;
			if (wr_rate)
			begin
				up_rate_reg <= hwdata_i[RATE_UP_LSB +: 14];
				dn_rate_reg <= hwdata_i[RATE_DN_LSB +: 14];
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			ramp_reg <= RAMP_HOLD;
			freq_reg <= FREQ_RST;
			tick_reg <= 14'h0000;
		end
		else
		begin
			ramp_reg <= ramp_next;
			freq_reg <= freq_next;
			tick_reg <= tick_next;
		end
	end

	// Completion and interrupt; hardware set beats write-one clear
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			busy_reg    <= 1'b0;
			wait_reg    <= 1'b0;
			st_rd_reg   <= 1'b0;
			st_stop_reg <= 1'b0;
			int_reg     <= 1'b0;
		end
		else
		begin
			busy_reg    <= gen_i.done ? 1'b0 : (gen_i.pulse ? 1'b1 : busy_reg);
			wait_reg    <= gen_i.done | (wait_reg & ~inp_active);
			st_rd_reg   <= rd_fire | (st_rd_reg & ~(wr_stat & hwdata_i[STAT_RDINT]));
			st_stop_reg <= stop_fire | (st_stop_reg & ~(wr_stat & hwdata_i[STAT_STOP]));
			int_reg     <= stop_fire | rd_fire;
		end
	end

	// Output pins, idle level follows polarity
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			step_out_reg <= 1'b1;
			dir_out_reg  <= 1'b1;
			el_reg       <= 1'b0;
		end
		else
		begin
			step_out_reg <= (gen_i.pulse & ~inhibit) ^ ~out_pol;
			if (!inhibit)
				dir_out_reg <= gen_i.dir_cw ^ out_pol;
			el_reg       <= end_limit_input_i & ~inhibit;
		end
	end

	assign step_pulse_output_o = step_out_reg;
	assign direction_output_o  = dir_out_reg;
	assign end_limit_valid_o   = el_reg;
	assign hold_o              = ~busy_reg;
	assign interrupt_o         = int_reg;
	assign forced_ramp_busy_o  = (ramp_reg != RAMP_HOLD);
	assign shared_pin_o        = phase_sel ? pattern : ind_i;
	assign hreadyout_o         = 1'b1;
	assign hresp_o             = 1'b0;

	AST_INT_STOP: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		wait_reg && inp_active |=> interrupt_o && st_stop_reg)
		else $error("stop interrupt missing after in-position");
	AST_INT_HELD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		inp_en && $rose(wait_reg) && !inp_active |-> interrupt_o == $past(rd_fire))
		else $error("interrupt raised before in-position");
	AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		gen_i.done |=> hold_o)
		else $error("hold not asserted on completion");
	AST_INHIBIT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		inhibit |=> step_pulse_output_o == ~$past(out_pol) && !end_limit_valid_o)
		else $error("inhibited output still active");
	AST_POL: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		gen_i.pulse && !inhibit && out_pol |=> step_pulse_output_o)
		else $error("positive pulse polarity wrong");
	AST_RDINT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		rd_fire |=> interrupt_o ##0 st_rd_reg)
		else $error("ramp-down interrupt missing");
	AST_FUP: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!force_up && !force_dn && ramp_reg == RAMP_HOLD |=> $stable(freq_reg))
		else $error("frequency moved while not forced");
	AST_FMAX: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		freq_reg == STEP_MAX && !force_dn |=> freq_reg == STEP_MAX)
		else $error("frequency passed top step");
	AST_PHSEL: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		phase_sel |-> shared_pin_o == pattern && (five_ph || !pattern[4]))
		else $error("phase routing or fifth bit wrong");
endmodule

// ===== logic/pulse_gen_pkg.sv
// Constants, field layout and carriers for the extension mode configuration block.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
package pulse_gen_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CFG  = 8'h00;
	localparam logic [7:0] ADDR_POS  = 8'h04;
	localparam logic [7:0] ADDR_RATE = 8'h08;
	localparam logic [7:0] ADDR_FREQ = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	// Configuration field positions
	localparam int CFG_PRE_LSB = 0;
	localparam int CFG_SRC_LSB = 4;
	localparam int CFG_INP_POL = 8;
	localparam int CFG_INP_EN  = 9;
	localparam int CFG_INHIBIT = 10;
	localparam int CFG_OUT_POL = 11;
	localparam int CFG_IN_POL  = 12;
	localparam int CFG_RDINT   = 13;
	localparam int CFG_FUP     = 14;
	localparam int CFG_FDN     = 15;
	localparam int CFG_PAT_LSB = 16;
	localparam int CFG_HALF    = 21;
	localparam int CFG_FIVE    = 22;
	localparam int CFG_PHSEL   = 23;
	// Rate register fields
	localparam int RATE_UP_LSB = 0;
	localparam int RATE_DN_LSB = 16;
	// Status register fields
	localparam int STAT_RDINT = 0;
	localparam int STAT_STOP  = 1;
	localparam int STAT_WAIT  = 2;
	localparam int STAT_HOLD  = 3;
	// Reset values and frequency step limits
	localparam logic [23:0] CFG_RST  = 24'h000000;
	localparam logic [23:0] POS_RST  = 24'h000000;
	localparam logic [13:0] RATE_RST = 14'h0002;
	localparam logic [12:0] FREQ_RST = 13'h0000;
	localparam logic [12:0] STEP_MAX = 13'h1FFF;
	localparam logic [12:0] STEP_MIN = 13'h0000;

	typedef enum logic [2:0] {SRC_OUT, SRC_CWCCW, SRC_AB1, SRC_AB2, SRC_AB4} src_e;
	typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN} ramp_e;

	typedef struct packed {
		logic pulse;
		logic dir_cw;
		logic done;
		logic ramp_down_start;
		logic high_speed_prog;
		logic count_halt;
	} gen_s;

	typedef struct packed {
		logic zero;
		logic limit;
		logic decel;
		logic steady;
		logic accel;
	} ind_s;
endpackage

// ===== logic/position_feed.sv
// Turns the selected count source into prescaled up/down steps.
// Assumes external pins already synchronous to clk_sys_i.
`timescale 1ns/1ps
module position_feed
(
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire pulse_gen_pkg::src_e src_i,
	input  wire logic              in_pol_i,
	input  wire logic [3:0]        prescale_i,
	input  wire logic              halt_i,
	input  wire logic              gen_pulse_i,
	input  wire logic              gen_cw_i,
	input  wire logic              ext_a_i,
	input  wire logic              ext_b_i,
	output logic                   step_o,
	output logic                   up_o
);
	import pulse_gen_pkg::*;

	logic       a_reg;
	logic       b_reg;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       a_now;
	logic       b_now;
	logic       a_edge;
	logic       b_edge;
	logic       quad_up;
	logic       qual;
	logic       dir_up;
	logic       wrap;

	assign a_now   = in_pol_i ? ext_a_i : ~ext_a_i;
	assign b_now   = in_pol_i ? ext_b_i : ~ext_b_i;
	assign a_edge  = a_now ^ a_reg;
	assign b_edge  = b_now ^ b_reg;
	assign quad_up = a_now ^ b_reg;

	always_comb
	begin
		qual   = 1'b0;
		dir_up = 1'b1;
		case (src_i)
			SRC_OUT:
			begin
				qual   = gen_pulse_i;
				dir_up = gen_cw_i;
			end
			SRC_CWCCW:
			begin
				qual   = (a_edge & a_now) | (b_edge & b_now);
				dir_up = a_edge & a_now;
			end
			SRC_AB1:
			begin
				qual   = a_edge & a_now;
				dir_up = quad_up;
			end
			SRC_AB2:
			begin
				qual   = a_edge;
				dir_up = quad_up;
			end
			SRC_AB4:
			begin
				qual   = a_edge | b_edge;
				dir_up = quad_up;
			end
			default:
			begin
				qual   = 1'b0;
				dir_up = 1'b1;
			end
		endcase
	end

	assign wrap     = (cnt_reg == prescale_i);
	assign cnt_next = (qual & ~halt_i) ? (wrap ? 4'h0 : cnt_reg + 4'h1) : cnt_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			a_reg   <= 1'b0;
			b_reg   <= 1'b0;
			cnt_reg <= 4'h0;
			step_o  <= 1'b0;
			up_o    <= 1'b1;
		end
		else
		begin
			a_reg   <= a_now;
			b_reg   <= b_now;
			cnt_reg <= cnt_next;
			step_o  <= qual & ~halt_i & wrap;
			up_o    <= dir_up;
		end
	end
endmodule

// ===== logic/phase_distributor.sv
// Four or five phase stepping pattern, loadable and advancing; a load wins over an advance in the same cycle.
// Assumes one advance request per cycle at most.
`timescale 1ns/1ps
module phase_distributor
(
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	input  wire logic       load_i,
	input  wire logic [4:0] load_val_i,
	input  wire logic       advance_i,
	input  wire logic       cw_i,
	input  wire logic       half_i,
	input  wire logic       five_i,
	output logic [4:0]      pattern_o
);
	logic [4:0] pat_next;
	logic [4:0] rl;
	logic [4:0] rr;
	logic [4:0] low_pair;
	logic [4:0] high_pair;

	// Rotation wraps at bit 3 for four phases, fifth bit stays clear
	assign rl = five_i ? {pattern_o[3:0], pattern_o[4]} : {1'b0, pattern_o[2:0], pattern_o[3]};
	assign rr = five_i ? {pattern_o[0], pattern_o[4:1]} : {1'b0, pattern_o[0], pattern_o[3:1]};
	assign low_pair  = pattern_o & rr;
	assign high_pair = pattern_o & rl;

	always_comb
	begin
		pat_next = pattern_o;
		if (load_i)
			pat_next = five_i ? load_val_i : {1'b0, load_val_i[3:0]};
		else if (advance_i)
		begin
			if (!half_i)
				pat_next = cw_i ? rl : rr;
			else if (cw_i)
				pat_next = (|low_pair) ? (pattern_o & ~low_pair) : (pattern_o | rl);
			else
				pat_next = (|high_pair) ? (pattern_o & ~high_pair) : (pattern_o | rr);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			pattern_o <= 5'h00;
		else
			pattern_o <= pat_next;
	end
endmodule

// ===== dv/motor_drive_model.sv
// Motor driver and encoder stand-in for the configuration block bench.
// Assumes the bench hands it the active level of every line it watches or drives.
`timescale 1ns/1ps
module motor_drive_model
#(
	parameter int SETTLE = 20
)
(
	input  wire logic clk_sys_i,
	input  wire logic step_active_i,
	input  wire logic inp_high_i,
	input  wire logic enc_high_i,
	output logic      in_position_o,
	output logic      enc_a_o,
	output logic      enc_b_o
);
	int   settle_cnt = 0;
	logic a_raw      = 1'b0;
	logic b_raw      = 1'b0;

	// Shaft lags the last pulse, so arrival is reported late
	always @(posedge clk_sys_i)
		if (step_active_i === 1'b1)
			settle_cnt <= SETTLE;
		else if (settle_cnt > 0)
			settle_cnt <= settle_cnt - 1;

	assign in_position_o = ~((settle_cnt == 0) ^ inp_high_i);
	assign enc_a_o       = ~(a_raw ^ enc_high_i);
	assign enc_b_o       = ~(b_raw ^ enc_high_i);

	// Forward means A leads; in pulse mode A carries the forward pulses
	task automatic run(input int n, input logic fwd, input logic quad);
		for (int i = 0; i < (quad ? 4 * n : 2 * n); i++)
		begin
			repeat (2) @(posedge clk_sys_i);
			if (quad ? ((i % 2 == 0) == fwd) : fwd)
				a_raw <= ~a_raw;
			else
				b_raw <= ~b_raw;
		end
	endtask
endmodule

// ===== dv/pulse_gen_ext_mode_config_one_tb.sv
// Self-checking bench for the extension mode configuration block.
// Assumes the bus tasks are the only register master and the motor model drives the pins.
`timescale 1ns/1ps
module pulse_gen_ext_mode_config_one_tb;
	import pulse_gen_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic        hsel      = 1'b0;
	logic [7:0]  haddr     = 8'h00;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = 32'h0;
	gen_s        gen       = '0;
	ind_s        ind       = '0;
	logic        end_limit = 1'b0;
	logic        inp_high  = 1'b0;
	logic        enc_high  = 1'b1;
	logic [23:0] cfg       = 24'h0;
	logic [31:0] rd;
	logic [31:0] frz;
	logic        pol;
	logic        fwd;
	int          pre;
	int          n;
	int          irq0;
	int          exp_pos;
	int          n_mismatch = 0;
	int          checks     = 0;
	int          n_irq      = 0;
	wire  [31:0] hrdata;
	wire  [4:0]  shared;
	wire         hready, hresp, step_o, dir_o, el_o, hold, irq, ramp_busy, inp, enc_a, enc_b;
	logic [3:0]  full_q[$]  = '{4'h3, 4'h6, 4'hC, 4'h9};
	logic [3:0]  half_q[$]  = '{4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9, 4'h1};
	logic [3:0]  src_t[4]   = '{4'h8, 4'hC, 4'hE, 4'hF};
	int          mul_t[4]   = '{1, 1, 2, 4};

	pulse_gen_ext_mode_config_one #(.POS_W(24)) i_pulse_gen_ext_mode_config_one (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.gen_i(gen), .ind_i(ind), .in_position_input_i(inp), .end_limit_input_i(end_limit),
		.ext_a_i(enc_a), .ext_b_i(enc_b), .step_pulse_output_o(step_o),
		.direction_output_o(dir_o), .end_limit_valid_o(el_o), .hold_o(hold),
		.interrupt_o(irq), .forced_ramp_busy_o(ramp_busy), .shared_pin_o(shared));

	motor_drive_model #(.SETTLE(20)) i_motor_drive_model (
		.clk_sys_i(clk_sys_i), .step_active_i(step_o ~^ cfg[11]), .inp_high_i(inp_high),
		.enc_high_i(enc_high), .in_position_o(inp), .enc_a_o(enc_a), .enc_b_o(enc_b));

	always #10 clk_sys_i = ~clk_sys_i;

	// Interrupts are single-cycle, so count them rather than poll the pin
	always @(posedge clk_sys_i)
		if (irq === 1'b1)
			n_irq <= n_irq + 1;

	task automatic report(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		report(got, exp);
	endtask

	task automatic cmp_pin(input logic [4:0] got, input logic [4:0] exp);
		report({27'h0, got}, {27'h0, exp});
	endtask

	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge clk_sys_i);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		// No wait limit here: only the watchdog ends a stuck transfer
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		cmp_reg(rd & m, e);
	endtask

	task automatic set_cfg(input logic [23:0] v);
		cfg = v;
		bus(ADDR_CFG, 1'b1, {8'h0, v});
	endtask

	task automatic gen_step(input logic cw);
		@(posedge clk_sys_i);
		gen.dir_cw <= cw;
		gen.pulse  <= 1'b1;
		@(posedge clk_sys_i);
		gen.pulse  <= 1'b0;
	endtask

	// Completion event when dn is set, ramp-down start otherwise
	task automatic ev(input logic dn);
		@(posedge clk_sys_i);
		gen.done            <= dn;
		gen.ramp_down_start <= ~dn;
		@(posedge clk_sys_i);
		gen.done            <= 1'b0;
		gen.ramp_down_start <= 1'b0;
	endtask

	task automatic wait_n(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wrap_up;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_sys_i);
		n_mismatch++;
		wrap_up;
	end

	initial
	begin
		void'($urandom(32'hBEF9));
		repeat (5) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd_chk(ADDR_CFG, 32'hFFFFFFFF, 32'h0);
		rd_chk(ADDR_RATE, 32'hFFFFFFFF, {2'h0, RATE_RST, 2'h0, RATE_RST});
		bus(8'h20, 1'b1, 32'hFFFFFFFF);
		rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
		cmp_pin({hresp, hold, 3'h0}, 5'h08);
		for (int p = 0; p < 2; p++)
		begin
			set_cfg({12'h0, p[0], 11'h0});
			wait_n(2);
			cmp_pin({4'h0, step_o}, {4'h0, ~p[0]});
			gen_step(1'b1);
			#1;
			cmp_pin({3'h0, step_o, dir_o}, {3'h0, p[0], ~p[0]});
		end
		set_cfg(24'h00040F);
		end_limit <= 1'b1;
		bus(ADDR_POS, 1'b1, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			gen_step(1'b1);
			#1;
			cmp_pin({3'h0, step_o, el_o}, 5'h02);
		end
		rd_chk(ADDR_POS, 32'hFFFFFF, 32'h1);
		gen.count_halt <= 1'b1;
		repeat (16) gen_step(1'b1);
		rd_chk(ADDR_POS, 32'hFFFFFF, 32'h1);
		gen.count_halt <= 1'b0;
		set_cfg(24'h00000F);
		wait_n(2);
		cmp_pin({4'h0, el_o}, 5'h01);
		for (int m = 0; m < 4; m++)
		begin
			pre = $urandom % 16;
			pol = 1'($urandom % 2);
			fwd = 1'($urandom % 2);
			n   = (pre + 1) * (1 + $urandom % 2);
			// Source parked on output pulses so a polarity swap makes no count
			set_cfg({11'h0, pol, 8'h0, pre[3:0]});
			enc_high <= pol;
			wait_n(3);
			set_cfg({11'h0, pol, 4'h0, src_t[m], pre[3:0]});
			bus(ADDR_POS, 1'b1, 32'h0);
			i_motor_drive_model.run(n, fwd, m != 0);
			wait_n(4);
			exp_pos = (fwd ? n : -n) * mul_t[m] / (pre + 1);
			rd_chk(ADDR_POS, 32'hFFFFFF, exp_pos & 32'hFFFFFF);
		end
		for (int p = 0; p < 2; p++)
		begin
			set_cfg({14'h0, 1'b1, p[0], 8'h0});
			inp_high <= p[0];
			repeat (2) gen_step(1'b1);
			ev(1'b1);
			irq0 = n_irq;
			wait_n(3);
			cmp_pin({3'h0, hold, 1'(irq0 == n_irq)}, 5'h03);
			wait_n(30);
			cmp_reg(n_irq - irq0, 1);
			rd_chk(ADDR_STAT, 32'h3, 32'h2);
			bus(ADDR_STAT, 1'b1, 32'h3);
			rd_chk(ADDR_STAT, 32'h3, 32'h0);
		end
		set_cfg(24'h0);
		gen_step(1'b1);
		ev(1'b1);
		irq0 = n_irq;
		wait_n(3);
		cmp_reg(n_irq - irq0, 1);
		bus(ADDR_STAT, 1'b1, 32'h3);
		gen.high_speed_prog <= 1'b1;
		for (int p = 1; p >= 0; p--)
		begin
			set_cfg({10'h0, p[0], 13'h0});
			ev(1'b0);
			irq0 = n_irq;
			wait_n(3);
			cmp_reg(n_irq - irq0, p);
			rd_chk(ADDR_STAT, 32'h1, p);
			bus(ADDR_STAT, 1'b1, 32'h3);
		end
		gen.high_speed_prog <= 1'b0;
		for (int h = 0; h < 2; h++)
		begin
			set_cfg({2'h2, h[0], 5'h13, 16'h0});
			rd_chk(ADDR_CFG, 32'h1F0000, 32'h030000);
			for (int i = 1; i <= 4 + 4 * h; i++)
			begin
				gen_step(1'b1);
				wait_n(2);
				cmp_pin(shared, h ? half_q[i % 8] : full_q[i % 4]);
			end
			gen_step(1'b0);
			wait_n(2);
			cmp_pin(shared, h ? half_q[7] : full_q[3]);
		end
		set_cfg(24'hD30000);
		rd_chk(ADDR_CFG, 32'h1F0000, 32'h130000);
		gen_step(1'b1);
		wait_n(2);
		cmp_pin(shared, 5'h07);
		set_cfg(24'h030000);
		ind <= ind_s'(5'($urandom % 32));
		gen_step(1'b1);
		wait_n(2);
		cmp_pin(shared, ind);
		rd_chk(ADDR_CFG, 32'h1F0000, 32'h060000);
		bus(ADDR_RATE, 1'b1, 32'h00010001);
		set_cfg(24'h004000);
		wait_n(40);
		cmp_pin({4'h0, ramp_busy}, 5'h01);
		set_cfg(24'h0);
		bus(ADDR_FREQ, 1'b0, 32'h0);
		frz = rd;
		wait_n(20);
		rd_chk(ADDR_FREQ, 32'h1FFF, frz);
		cmp_reg(frz > 30, 1);
		set_cfg(24'h004000);
		wait_n(8300);
		rd_chk(ADDR_FREQ, 32'h1FFF, STEP_MAX);
		set_cfg(24'h008000);
		wait_n(8300);
		rd_chk(ADDR_FREQ, 32'h1FFF, STEP_MIN);
		cmp_pin({4'h0, ramp_busy}, 5'h00);
		wrap_up;
	end
endmodule
